//--- src/tbgp_port.sv
// two-bit general-purpose port with slow oscillator pin sharing
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module tbgp_port
  import tbgp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`TBGP_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pins
  input wire tbgp_bits_t pin_in,
  output tbgp_bits_t pin_out,
  output tbgp_bits_t pin_oe_n_out,
  // pad controls
  output tbgp_bits_t pullup_out,
  output tbgp_bits_t pulldown_out,
  output tbgp_bits_t input_en_out,
  output logic slow_osc_en_out
);

  typedef struct packed {
    tbgp_bits_t pin_value_bits;
    tbgp_bits_t output_enable_bits;
    tbgp_bits_t drain_mode_bits;
    tbgp_bits_t pullup_bits;
    tbgp_bits_t pulldown_bits;
    tbgp_bits_t input_enable_bits;
    logic osc_en;
    tbgp_bits_t pin_drv;
    tbgp_bits_t pin_oe_n;
    tbgp_bits_t pu_pad;
    tbgp_bits_t pd_pad;
    tbgp_bits_t ie_pad;
    logic osc_pad;
  } tbgp_port_s;

  tbgp_port_s state_reg;
  tbgp_port_s state_next;
  tbgp_bits_t pin_sync;
  tbgp_bits_t read_bits;

  tbgp_reg_if reg_bus ();

  tbgp_apb_slave apb_slave (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .reg_bus(reg_bus.slave)
  );

  tbgp_pin_sync pin_sync_u (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .raw_in(pin_in),
    .stable_out(pin_sync)
  );

  // blocked input reads the output latch if driving, else zero
  assign read_bits = (state_reg.input_enable_bits & pin_sync)
    | (~state_reg.input_enable_bits & state_reg.output_enable_bits
       & state_reg.pin_value_bits);

  always_comb begin
    reg_bus.rd_data = `TBGP_ZERO_WORD;
    case (reg_bus.rd_sel)
      TBGP_R_VALUE: reg_bus.rd_data[1:0] = read_bits;
      TBGP_R_OE: reg_bus.rd_data[1:0] = state_reg.output_enable_bits;
      TBGP_R_OD: reg_bus.rd_data[1:0] = state_reg.drain_mode_bits;
      TBGP_R_PU: reg_bus.rd_data[1:0] = state_reg.pullup_bits;
      TBGP_R_PD: reg_bus.rd_data[1:0] = state_reg.pulldown_bits;
      TBGP_R_IE: reg_bus.rd_data[1:0] = state_reg.input_enable_bits;
      TBGP_R_OSC: reg_bus.rd_data[`TBGP_OSC_BIT] = state_reg.osc_en;
      default: reg_bus.rd_data = `TBGP_ZERO_WORD;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    // only bits 1:0 are kept, upper write data is dropped
    if (reg_bus.wr_stb) begin
      case (reg_bus.wr_sel)
        TBGP_R_VALUE: state_next.pin_value_bits = reg_bus.wr_data[1:0];
        TBGP_R_OE:
          state_next.output_enable_bits = reg_bus.wr_data[1:0];
        TBGP_R_OD: state_next.drain_mode_bits = reg_bus.wr_data[1:0];
        TBGP_R_PU: state_next.pullup_bits = reg_bus.wr_data[1:0];
        TBGP_R_PD: state_next.pulldown_bits = reg_bus.wr_data[1:0];
        TBGP_R_IE:
          state_next.input_enable_bits = reg_bus.wr_data[1:0];
        // no interlock on pin level: software keeps that ordering
        TBGP_R_OSC:
          state_next.osc_en = reg_bus.wr_data[`TBGP_OSC_BIT];
        default: state_next.osc_en = state_reg.osc_en;
      endcase
    end
    // each pin drives on its own enable bit
    for (int i = 0; i < $bits(tbgp_bits_t); i++) begin
      // open drain pulls low only, a one releases the pin
      state_next.pin_drv[i] = state_reg.drain_mode_bits[i]
        ? 1'b0 : state_reg.pin_value_bits[i];
      state_next.pin_oe_n[i] = !(state_reg.output_enable_bits[i]
        && !(state_reg.drain_mode_bits[i]
             && state_reg.pin_value_bits[i]));
    end
    state_next.pu_pad = state_reg.pullup_bits;
    state_next.pd_pad = state_reg.pulldown_bits;
    state_next.ie_pad = state_reg.input_enable_bits;
    state_next.osc_pad = state_reg.osc_en;
    // oscillator owns the pins: all port drive and pads are cut
    if (state_reg.osc_en) begin
      state_next.pin_oe_n = `TBGP_ALL_OFF_N;
      state_next.pu_pad = `TBGP_RST_BITS;
      state_next.pd_pad = `TBGP_RST_BITS;
      state_next.ie_pad = `TBGP_RST_BITS;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.pin_oe_n <= `TBGP_ALL_OFF_N;
      state_reg.osc_en <= `TBGP_RST_OSC;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_out = state_reg.pin_drv;
  assign pin_oe_n_out = state_reg.pin_oe_n;
  assign pullup_out = state_reg.pu_pad;
  assign pulldown_out = state_reg.pd_pad;
  assign input_en_out = state_reg.ie_pad;
  assign slow_osc_en_out = state_reg.osc_pad;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  reset_config_a: assert property (
    $rose(rst_n_in) |-> (state_reg.output_enable_bits == `TBGP_RST_BITS
      && state_reg.input_enable_bits == `TBGP_RST_BITS
      && state_reg.pullup_bits == `TBGP_RST_BITS
      && state_reg.pulldown_bits == `TBGP_RST_BITS
      && pin_oe_n_out == `TBGP_ALL_OFF_N))
    else $error("port not cleared by reset");

  osc_reset_a: assert property (
    $rose(rst_n_in) |-> !slow_osc_en_out ##1 !slow_osc_en_out)
    else $error("oscillator running after reset");

  value_write_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_VALUE
      |=> state_reg.pin_value_bits == $past(reg_bus.wr_data[1:0]))
    else $error("pin value write lost");

  oe_drive_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_OE
      && reg_bus.wr_data[0] && !state_reg.osc_en
      && !state_reg.drain_mode_bits[0]
      && !(reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_OSC)
      |=> ##1 !pin_oe_n_out[0])
    else $error("enabled pin not driven");

  od_release_a: assert property (
    state_reg.drain_mode_bits[1] && state_reg.pin_value_bits[1]
      |=> pin_oe_n_out[1] && !pin_out[1])
    else $error("open drain drove high");

  pullup_pad_a: assert property (
    ##1 pullup_out == ($past(state_reg.osc_en)
      ? `TBGP_RST_BITS : $past(state_reg.pullup_bits)))
    else $error("pull-up pad mismatch");

  pulldown_pad_a: assert property (
    ##1 pulldown_out == ($past(state_reg.osc_en)
      ? `TBGP_RST_BITS : $past(state_reg.pulldown_bits)))
    else $error("pull-down pad mismatch");

  input_block_a: assert property (
    psel_in && !penable_in && !pwrite_in
      && tbgp_decode(paddr_in) == TBGP_R_VALUE
      && !state_reg.input_enable_bits[0]
      && !state_reg.output_enable_bits[0]
      |=> pready_out && !prdata_out[0])
    else $error("blocked input visible");

  upper_zero_a: assert property (
    pready_out |-> prdata_out[31:2] == '0)
    else $error("upper read bits not zero");

  osc_isolate_a: assert property (
    state_reg.osc_en |=> pin_oe_n_out == `TBGP_ALL_OFF_N
      && input_en_out == `TBGP_RST_BITS && slow_osc_en_out)
    else $error("pins not released to oscillator");

  oe_write_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_OE
      |=> state_reg.output_enable_bits == $past(reg_bus.wr_data[1:0]))
    else $error("output enable write lost");

  od_write_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_OD
      |=> state_reg.drain_mode_bits == $past(reg_bus.wr_data[1:0]))
    else $error("drain mode write lost");

  pu_write_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_PU
      |=> state_reg.pullup_bits == $past(reg_bus.wr_data[1:0]))
    else $error("pull-up write lost");

  pd_write_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_PD
      |=> state_reg.pulldown_bits == $past(reg_bus.wr_data[1:0]))
    else $error("pull-down write lost");

  ie_write_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_IE
      |=> state_reg.input_enable_bits == $past(reg_bus.wr_data[1:0]))
    else $error("input enable write lost");

  osc_write_a: assert property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_OSC
      |=> state_reg.osc_en == $past(reg_bus.wr_data[`TBGP_OSC_BIT]))
    else $error("oscillator enable write lost");

  pp_drive_a: assert property (
    state_reg.output_enable_bits[0] && !state_reg.drain_mode_bits[0]
      && !state_reg.osc_en
      |=> !pin_oe_n_out[0]
        && pin_out[0] == $past(state_reg.pin_value_bits[0]))
    else $error("push-pull pin not driven");

  od_low_a: assert property (
    state_reg.output_enable_bits[0] && state_reg.drain_mode_bits[0]
      && !state_reg.pin_value_bits[0] && !state_reg.osc_en
      |=> !pin_oe_n_out[0] && !pin_out[0])
    else $error("open drain did not pull low");

  oe_off_a: assert property (
    !state_reg.output_enable_bits[1] |=> pin_oe_n_out[1])
    else $error("disabled pin driven");

  ie_pad_a: assert property (
    ##1 input_en_out == ($past(state_reg.osc_en)
      ? `TBGP_RST_BITS : $past(state_reg.input_enable_bits)))
    else $error("input enable pad mismatch");

  read_latch_a: assert property (
    psel_in && !penable_in && !pwrite_in
      && tbgp_decode(paddr_in) == TBGP_R_VALUE
      && !state_reg.input_enable_bits[0]
      && state_reg.output_enable_bits[0]
      |=> prdata_out[0] == $past(state_reg.pin_value_bits[0]))
    else $error("driven pin reads wrong value");

  unmapped_ignore_a: assert property (
    psel_in && penable_in && pready_out
      && tbgp_decode(paddr_in) == TBGP_R_NONE
      |=> $stable({state_reg.pin_value_bits, state_reg.output_enable_bits,
        state_reg.drain_mode_bits, state_reg.pullup_bits,
        state_reg.pulldown_bits, state_reg.input_enable_bits,
        state_reg.osc_en}))
    else $error("unmapped write changed a register");

  oe_write_c: cover property (
    reg_bus.wr_stb && reg_bus.wr_sel == TBGP_R_OE ##2 !pin_oe_n_out[0]);
  osc_on_c: cover property (!slow_osc_en_out ##1 slow_osc_en_out);
  input_read_c: cover property (
    pready_out && state_reg.input_enable_bits[0] && prdata_out[0]);
  slverr_c: cover property (pready_out && pslverr_out);

endmodule

`default_nettype wire

//--- shared/tbgp_map.svh
// register map, reset values and fixed constants of the two-bit port
`ifndef TBGP_MAP_SVH
`define TBGP_MAP_SVH

`define TBGP_AW 12
`define TBGP_OFF_VALUE 12'h000
`define TBGP_OFF_OE 12'h004
`define TBGP_OFF_OD 12'h028
`define TBGP_OFF_PU 12'h02C
`define TBGP_OFF_PD 12'h030
`define TBGP_OFF_IE 12'h038
`define TBGP_OFF_OSC 12'h040

`define TBGP_RST_BITS 2'h0
`define TBGP_RST_OSC 1'h0
`define TBGP_ALL_OFF_N 2'h3
`define TBGP_ZERO_WORD 32'h0000_0000
`define TBGP_OSC_BIT 0

`endif

//--- shared/tbgp_pkg.sv
// types and address decode of the two-bit port
`default_nettype none
`include "tbgp_map.svh"

package tbgp_pkg;

  typedef logic [1:0] tbgp_bits_t;

  typedef enum {
    TBGP_R_VALUE,
    TBGP_R_OE,
    TBGP_R_OD,
    TBGP_R_PU,
    TBGP_R_PD,
    TBGP_R_IE,
    TBGP_R_OSC,
    TBGP_R_NONE
  } tbgp_reg_e;

  function automatic tbgp_reg_e tbgp_decode(
    input logic [`TBGP_AW-1:0] addr
  );
    case (addr)
      `TBGP_OFF_VALUE: tbgp_decode = TBGP_R_VALUE;
      `TBGP_OFF_OE: tbgp_decode = TBGP_R_OE;
      `TBGP_OFF_OD: tbgp_decode = TBGP_R_OD;
      `TBGP_OFF_PU: tbgp_decode = TBGP_R_PU;
      `TBGP_OFF_PD: tbgp_decode = TBGP_R_PD;
      `TBGP_OFF_IE: tbgp_decode = TBGP_R_IE;
      `TBGP_OFF_OSC: tbgp_decode = TBGP_R_OSC;
      default: tbgp_decode = TBGP_R_NONE;
    endcase
  endfunction

endpackage

`default_nettype wire

//--- shared/tbgp_reg_if.sv
// register access path between the bus slave and the port core
`timescale 1ns/1ns
`default_nettype none

interface tbgp_reg_if;
  import tbgp_pkg::*;
  logic wr_stb;
  tbgp_reg_e wr_sel;
  logic [31:0] wr_data;
  tbgp_reg_e rd_sel;
  logic [31:0] rd_data;

  modport slave (
    output wr_stb,
    output wr_sel,
    output wr_data,
    output rd_sel,
    input rd_data
  );

  modport core (
    input wr_stb,
    input wr_sel,
    input wr_data,
    input rd_sel,
    output rd_data
  );
endinterface

`default_nettype wire

//--- src/tbgp_pin_sync.sv
// three-stage synchroniser for the two pin inputs
`timescale 1ns/1ns
`default_nettype none

module tbgp_pin_sync
  import tbgp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // pins and result
  input wire tbgp_bits_t raw_in,
  output tbgp_bits_t stable_out
);

  typedef struct packed {
    tbgp_bits_t s1;
    tbgp_bits_t s2;
    tbgp_bits_t s3;
    tbgp_bits_t stable;
  } tbgp_sync_s;

  tbgp_sync_s sync_reg;
  tbgp_sync_s sync_next;

  // a level counts only once stages two and three agree
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = raw_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < $bits(tbgp_bits_t); i++) begin
      if (sync_reg.s2[i] == sync_reg.s3[i]) begin
        sync_next.stable[i] = sync_reg.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign stable_out = sync_reg.stable;

endmodule

`default_nettype wire

//--- src/tbgp_apb_slave.sv
// apb slave front end, zero wait states
`timescale 1ns/1ns
`default_nettype none

module tbgp_apb_slave
  import tbgp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`TBGP_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // register path
  tbgp_reg_if.slave reg_bus
);

  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } tbgp_apb_s;

  tbgp_apb_s apb_reg;
  tbgp_apb_s apb_next;
  tbgp_reg_e sel;

  assign sel = tbgp_decode(paddr_in);
  assign reg_bus.rd_sel = sel;
  assign reg_bus.wr_sel = sel;
  assign reg_bus.wr_data = pwdata_in;
  // write lands only at the completing access edge
  assign reg_bus.wr_stb = psel_in & penable_in & apb_reg.ready
    & pwrite_in & (sel != TBGP_R_NONE);

  // read data is caught in setup so prdata comes from a flop
  always_comb begin
    apb_next = apb_reg;
    apb_next.ready = 1'b0;
    if (psel_in && !penable_in) begin
      apb_next.ready = 1'b1;
      apb_next.slverr = (sel == TBGP_R_NONE);
      apb_next.rdata = `TBGP_ZERO_WORD;
      if (!pwrite_in && sel != TBGP_R_NONE) begin
        apb_next.rdata = reg_bus.rd_data;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      apb_reg <= '0;
    end else begin
      apb_reg <= apb_next;
    end
  end

  assign prdata_out = apb_reg.rdata;
  assign pready_out = apb_reg.ready;
  assign pslverr_out = apb_reg.slverr;

endmodule

`default_nettype wire

//--- tb/tbgp_pad_model.sv
// pad model: resolves each pin from port drive, pulls and a far driver
`timescale 1ns/1ns
`default_nettype none

module tbgp_pad_model
  import tbgp_pkg::*;
(
  // from the port
  input wire tbgp_bits_t drv_in,
  input wire tbgp_bits_t oe_n_in,
  input wire tbgp_bits_t pu_in,
  input wire tbgp_bits_t pd_in,
  // far driver
  input wire tbgp_bits_t ext_en_in,
  input wire tbgp_bits_t ext_val_in,
  // resolved level
  output tbgp_bits_t level_out
);
  tbgp_bits_t flt;
  initial flt = 2'h1;
  // a floating pin wanders so no check leans on a stale level
  always #7 flt = ~flt;
  always @* begin
    for (int i = 0; i < 2; i++) begin
      if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (!oe_n_in[i]) level_out[i] = drv_in[i];
      else if (pu_in[i]) level_out[i] = 1'b1;
      else if (pd_in[i]) level_out[i] = 1'b0;
      else level_out[i] = flt[i];
    end
  end
endmodule

`default_nettype wire

//--- tb/tbgp_port_tb.sv
// self-checking bench of the two-bit port
`timescale 1ns/1ns
`default_nettype none
`include "tbgp_map.svh"

module tbgp_port_tb;
  import tbgp_pkg::*;
  logic sys_clk_in = 0, rst_n_in = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, osc;
  tbgp_bits_t pin_out, oe_n, pu, pd, ie, lvl;
  tbgp_bits_t ext_en = 2'h0, ext_val = 2'h0;
  int fail_count = 0, tests_run = 0;
  logic [11:0] offs [5] = '{`TBGP_OFF_OE, `TBGP_OFF_OD, `TBGP_OFF_PU,
    `TBGP_OFF_PD, `TBGP_OFF_IE};

  always #5 sys_clk_in = ~sys_clk_in;

  tbgp_port tbgp_port_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pin_in(lvl),
    .pin_out(pin_out), .pin_oe_n_out(oe_n), .pullup_out(pu),
    .pulldown_out(pd), .input_en_out(ie), .slow_osc_en_out(osc));

  tbgp_pad_model tbgp_pad_model_i (.drv_in(pin_out), .oe_n_in(oe_n),
    .pu_in(pu), .pd_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(lvl));

  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  // pads settle one edge after the register write
  task automatic pad(input logic [8:0] x);
    repeat (2) @(posedge sys_clk_in);
    chk({23'h0, osc, oe_n, pu, pd, ie}, {23'h0, x});
  endtask

  task automatic s_reset();
    rd(`TBGP_OFF_VALUE, 32'h0);
    foreach (offs[i]) rd(offs[i], 32'h0);
    pad(9'h0C0);
    chk({30'h0, pin_out}, 32'h0);
  endtask

  task automatic s_regs();
    foreach (offs[i]) wr(offs[i], 32'hFFFF_FFFC | (i % 3 + 1));
    foreach (offs[i]) rd(offs[i], i % 3 + 1);
    pad(9'h0B6);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    s_reset();
  endtask

  task automatic s_dir();
    wr(`TBGP_OFF_OE, 32'h1);
    wr(`TBGP_OFF_VALUE, 32'hFFFF_FFFF);
    wr(`TBGP_OFF_IE, 32'h2);
    ext_en <= 2'h2;
    ext_val <= 2'h2;
    repeat (6) @(posedge sys_clk_in);
    rd(`TBGP_OFF_VALUE, 32'h3);
    chk({oe_n, 1'b0, pin_out[0]}, 32'h9);
    ext_val <= 2'h0;
    repeat (6) @(posedge sys_clk_in);
    rd(`TBGP_OFF_VALUE, 32'h1);
  endtask

  task automatic s_drain();
    ext_en <= 2'h0;
    wr(`TBGP_OFF_OD, 32'h3);
    wr(`TBGP_OFF_VALUE, 32'h0);
    wr(`TBGP_OFF_PU, 32'h1);
    wr(`TBGP_OFF_IE, 32'h1);
    pad(9'h091);
    chk({31'h0, pin_out[0]}, 32'h0);
    wr(`TBGP_OFF_VALUE, 32'h1);
    wr(`TBGP_OFF_PD, 32'h2);
    pad(9'h0D9);
    repeat (6) @(posedge sys_clk_in);
    rd(`TBGP_OFF_VALUE, 32'h1);
  endtask

  task automatic s_err();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000);
    wr(12'h008, 32'hFFFF_FFFF);
    rd(`TBGP_OFF_OE, 32'h1);
  endtask

  // pins held low by pull-downs before the oscillator is switched
  task automatic s_osc();
    wr(`TBGP_OFF_OE, 32'h0);
    wr(`TBGP_OFF_PU, 32'h0);
    wr(`TBGP_OFF_PD, 32'h3);
    wr(`TBGP_OFF_IE, 32'h3);
    pad(9'h0CF);
    chk({30'h0, lvl}, 32'h0);
    wr(`TBGP_OFF_OSC, 32'h1);
    pad(9'h1C0);
    rd(`TBGP_OFF_PD, 32'h3);
    // pulls are cut now, so the far side holds the pins low
    ext_val <= 2'h0;
    ext_en <= 2'h3;
    @(posedge sys_clk_in);
    chk({30'h0, lvl}, 32'h0);
    wr(`TBGP_OFF_OSC, 32'h0);
    pad(9'h0CF);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    s_reset();
    s_regs();
    s_dir();
    s_drain();
    s_err();
    s_osc();
    wrap_up();
  end

  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
